// [inc/brf_regs.svh]
`ifndef BRF_REGS_SVH
`define BRF_REGS_SVH

// Status word field positions.
`define BRF_STAT_TFLAG_POS 0
`define BRF_STAT_SFLAG_POS 1
`define BRF_STAT_IMASK_LSB 4
`define BRF_STAT_IMASK_MSB 7
`define BRF_STAT_QFLAG_POS 8
`define BRF_STAT_MFLAG_POS 9
`define BRF_STAT_HOLD_POS 28
`define BRF_STAT_BANK_POS 29
`define BRF_STAT_MODE_POS 30

// Implemented bits; every other status bit is reserved and stays zero.
`define BRF_STAT_IMPL_MASK 32'h700003F3
// Bits that only privileged code may read or write.
`define BRF_STAT_PRIV_MASK 32'h700000F0

// Reset values.
`define BRF_STAT_RST 32'h700000F0
`define BRF_VBASE_RST 32'h00000000
`define BRF_PC_RST 32'hA0000000
`define BRF_WORD_RST 32'h00000000

// Physical storage layout: bank zero, bank one, then the unbanked upper eight.
`define BRF_PHYS_BANK1_BASE 5'h08
`define BRF_PHYS_UPPER_BASE 5'h10
`define BRF_PHYS_DEPTH 24

`endif

// [inc/brf_pkg.sv]
package brf_pkg;

	typedef logic [31:0] brf_word_t;
	typedef logic [3:0] brf_gidx_t;
	typedef logic [4:0] brf_paddr_t;

	// Selector for load-control and store-control operations.
	typedef enum logic [3:0] {
		BRF_SEL_STATUS = 4'h0,
		BRF_SEL_SAVED_STATUS = 4'h1,
		BRF_SEL_SAVED_PC = 4'h2,
		BRF_SEL_GLOBAL_BASE = 4'h3,
		BRF_SEL_VECTOR_BASE = 4'h4,
		BRF_SEL_MAC_HIGH = 4'h5,
		BRF_SEL_MAC_LOW = 4'h6,
		BRF_SEL_RETURN_LINK = 4'h7,
		BRF_SEL_PC = 4'h8,
		BRF_SEL_ALT_BANK = 4'h9
	} brf_sel_e;

endpackage : brf_pkg

// [rtl/brf_bank_store.sv]
`timescale 1ns/1ps
`include "brf_regs.svh"

// Flat flip-flop storage for all physical general registers, one write port and three read ports.
module brf_bank_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 24,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	input wire logic [AW-1:0] raddr_b,
	input wire logic [AW-1:0] raddr_c,
	output logic [WIDTH-1:0] rdata_a,
	output logic [WIDTH-1:0] rdata_b,
	output logic [WIDTH-1:0] rdata_c
);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			// Each entry takes the write data only when its own address is selected.
			always_comb begin
				mem_nxt[g] = (we && (waddr == AW'(g))) ? wdata : mem_r[g];
			end

			// Cleared on reset so simulation never sees unknowns; software must not rely on it.
			always_ff @(posedge clk) begin
				if (rst) begin
					mem_r[g] <= '0;
				end else begin
					mem_r[g] <= mem_nxt[g];
				end
			end
		end
	endgenerate

	// Reads are combinational; the caller registers them.
	assign rdata_a = mem_r[raddr_a];
	assign rdata_b = mem_r[raddr_b];
	assign rdata_c = mem_r[raddr_c];

endmodule : brf_bank_store

// [rtl/brf_register_file.sv]
`timescale 1ns/1ps
`include "brf_regs.svh"

module brf_register_file import brf_pkg::*; #(
	parameter int NGEN = 16,
	parameter int NBANKED = 8
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [3:0] GEN_RD_A_IDX,
	input wire logic [3:0] GEN_RD_B_IDX,
	input wire logic GEN_WR_EN,
	input wire logic [3:0] GEN_WR_IDX,
	input wire logic [31:0] GEN_WR_DATA,
	input wire logic LOAD_CONTROL_OP,
	input wire logic STORE_CONTROL_OP,
	input wire logic [3:0] CTL_SEL,
	input wire logic [2:0] CTL_BANK_IDX,
	input wire logic [31:0] CTL_WDATA,
	input wire logic EXC_TAKE,
	input wire logic [31:0] EXC_TARGET,
	input wire logic RETURN_FROM_EXCEPTION,
	input wire logic PC_WR_EN,
	input wire logic [31:0] PC_WR_DATA,
	output logic [31:0] GEN_RD_A_DATA,
	output logic [31:0] GEN_RD_B_DATA,
	output logic [31:0] INDEX_R0,
	output logic [31:0] CTL_RDATA,
	output logic CTL_FAULT,
	output logic MODE_BIT,
	output logic BANK_SELECT_BIT,
	output logic EXCEPTION_HOLD_FLAG,
	output logic [3:0] INTERRUPT_MASK_FIELD,
	output logic [31:0] STATUS_WORD,
	output logic [31:0] PC_VALUE,
	output logic [31:0] GLOBAL_BASE,
	output logic [31:0] VECTOR_BASE
);

	// Maps an architectural index and a bank to a physical storage address.
	function automatic brf_paddr_t phys_addr(input brf_gidx_t idx, input logic bank);
		brf_paddr_t pa;
		if (idx[3]) begin
			pa = `BRF_PHYS_UPPER_BASE + {2'b00, idx[2:0]};
		end else begin
			pa = (bank ? `BRF_PHYS_BANK1_BASE : 5'h00) + {2'b00, idx[2:0]};
		end
		return pa;
	endfunction : phys_addr

	// Registers that have a defined value after reset.
	brf_word_t stat_r, stat_nxt;
	brf_word_t pc_r, pc_nxt;
	brf_word_t vbase_r, vbase_nxt;
	// Registers whose reset value is left open; cleared here only for determinism.
	brf_word_t sstat_r, sstat_nxt;
	brf_word_t spc_r, spc_nxt;
	brf_word_t gbase_r, gbase_nxt;
	brf_word_t mac_high_r, mac_high_nxt;
	brf_word_t mac_low_r, mac_low_nxt;
	brf_word_t rlink_r, rlink_nxt;
	// Registered answers.
	brf_word_t rda_r, rda_nxt;
	brf_word_t rdb_r, rdb_nxt;
	brf_word_t idx0_r, idx0_nxt;
	brf_word_t crd_r, crd_nxt;
	logic fault_r, fault_nxt;

	logic priv;
	logic bank_use;
	logic ctl_any;
	logic ctl_ok;
	logic alt_wr;
	brf_sel_e sel;
	brf_paddr_t pa_rd_a, pa_rd_b, pa_rd_c;
	brf_paddr_t pa_wr;
	brf_word_t st_rd_a, st_rd_b, st_rd_c;
	brf_word_t st_wdata;
	logic st_we;
	brf_word_t r0_live;

	// Mode comes straight from the live status word, bank from its bank bit gated by mode (bank zero in user mode), so a write takes effect next cycle.
	assign priv = stat_r[`BRF_STAT_MODE_POS];
	assign bank_use = priv & stat_r[`BRF_STAT_BANK_POS];
	assign sel = brf_sel_e'(CTL_SEL);
	assign ctl_any = LOAD_CONTROL_OP | STORE_CONTROL_OP;

	// Privilege check for control operations.
	always_comb begin
		case (sel)
			BRF_SEL_STATUS, BRF_SEL_GLOBAL_BASE: ctl_ok = 1'b1;
			BRF_SEL_SAVED_STATUS, BRF_SEL_SAVED_PC, BRF_SEL_VECTOR_BASE: ctl_ok = priv;
			BRF_SEL_MAC_HIGH, BRF_SEL_MAC_LOW, BRF_SEL_RETURN_LINK, BRF_SEL_PC: ctl_ok = 1'b1;
			BRF_SEL_ALT_BANK: ctl_ok = priv;
			default: ctl_ok = 1'b0;
		endcase
	end

	// The inactive bank is reached only through control operations, addressed as its low eight.
	assign pa_rd_a = phys_addr(GEN_RD_A_IDX, bank_use);
	assign pa_rd_b = phys_addr(GEN_RD_B_IDX, bank_use);
	assign pa_rd_c = phys_addr({1'b0, CTL_BANK_IDX}, ~bank_use);
	assign alt_wr = LOAD_CONTROL_OP & ctl_ok & (sel == BRF_SEL_ALT_BANK);

	// Single storage write port; a bank load from a control op wins over a general write.
	always_comb begin
		st_we = alt_wr | GEN_WR_EN;
		pa_wr = alt_wr ? pa_rd_c : phys_addr(GEN_WR_IDX, bank_use);
		st_wdata = alt_wr ? CTL_WDATA : GEN_WR_DATA;
	end

	brf_bank_store #(
		.WIDTH(32),
		.DEPTH(`BRF_PHYS_DEPTH),
		.AW(5)
	) u_store (
		.clk(CLK_SYS),
		.rst(RST),
		.we(st_we),
		.waddr(pa_wr),
		.wdata(st_wdata),
		.raddr_a(pa_rd_a),
		.raddr_b(pa_rd_b),
		.raddr_c(pa_rd_c),
		.rdata_a(st_rd_a),
		.rdata_b(st_rd_b),
		.rdata_c(st_rd_c)
	);

	// Next state of the control and system registers; exception beats return, which beats loads.
	always_comb begin
		stat_nxt = stat_r;
		pc_nxt = PC_WR_EN ? PC_WR_DATA : pc_r;
		vbase_nxt = vbase_r;
		sstat_nxt = sstat_r;
		spc_nxt = spc_r;
		gbase_nxt = gbase_r;
		mac_high_nxt = mac_high_r;
		mac_low_nxt = mac_low_r;
		rlink_nxt = rlink_r;
		if (LOAD_CONTROL_OP && ctl_ok) begin
			case (sel)
				BRF_SEL_STATUS: begin
					if (priv) begin
						stat_nxt = CTL_WDATA & `BRF_STAT_IMPL_MASK;
					end else begin
						stat_nxt = (stat_r & `BRF_STAT_PRIV_MASK)
							| (CTL_WDATA & `BRF_STAT_IMPL_MASK & ~`BRF_STAT_PRIV_MASK);
					end
				end
				BRF_SEL_SAVED_STATUS: sstat_nxt = CTL_WDATA;
				BRF_SEL_SAVED_PC: spc_nxt = CTL_WDATA;
				BRF_SEL_GLOBAL_BASE: gbase_nxt = CTL_WDATA;
				BRF_SEL_VECTOR_BASE: vbase_nxt = CTL_WDATA;
				BRF_SEL_MAC_HIGH: mac_high_nxt = CTL_WDATA;
				BRF_SEL_MAC_LOW: mac_low_nxt = CTL_WDATA;
				BRF_SEL_RETURN_LINK: rlink_nxt = CTL_WDATA;
				BRF_SEL_PC: pc_nxt = CTL_WDATA;
				default: stat_nxt = stat_r;
			endcase
		end
		if (EXC_TAKE) begin
			sstat_nxt = stat_r;
			spc_nxt = pc_r;
			pc_nxt = EXC_TARGET;
			stat_nxt = stat_r;
			stat_nxt[`BRF_STAT_MODE_POS] = 1'b1;
			stat_nxt[`BRF_STAT_BANK_POS] = 1'b1;
			stat_nxt[`BRF_STAT_HOLD_POS] = 1'b1;
		end else if (RETURN_FROM_EXCEPTION) begin
			pc_nxt = spc_r;
			stat_nxt = sstat_r & `BRF_STAT_IMPL_MASK;
		end
	end

	// One synchronous reset serves both power-on and manual reset.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			stat_r <= `BRF_STAT_RST;
			pc_r <= `BRF_PC_RST;
			vbase_r <= `BRF_VBASE_RST;
			sstat_r <= `BRF_WORD_RST;
			spc_r <= `BRF_WORD_RST;
			gbase_r <= `BRF_WORD_RST;
			mac_high_r <= `BRF_WORD_RST;
			mac_low_r <= `BRF_WORD_RST;
			rlink_r <= `BRF_WORD_RST;
		end else begin
			stat_r <= stat_nxt;
			pc_r <= pc_nxt;
			vbase_r <= vbase_nxt;
			sstat_r <= sstat_nxt;
			spc_r <= spc_nxt;
			gbase_r <= gbase_nxt;
			mac_high_r <= mac_high_nxt;
			mac_low_r <= mac_low_nxt;
			rlink_r <= rlink_nxt;
		end
	end

	// Answers are registered so every output leaves a flip-flop; reads see state before this edge.
	always_comb begin
		rda_nxt = st_rd_a;
		rdb_nxt = st_rd_b;
		idx0_nxt = r0_live;
		fault_nxt = ctl_any & ~ctl_ok;
		crd_nxt = crd_r;
		if (STORE_CONTROL_OP && ctl_ok) begin
			case (sel)
				BRF_SEL_STATUS: crd_nxt = priv ? stat_r : (stat_r & ~`BRF_STAT_PRIV_MASK);
				BRF_SEL_SAVED_STATUS: crd_nxt = sstat_r;
				BRF_SEL_SAVED_PC: crd_nxt = spc_r;
				BRF_SEL_GLOBAL_BASE: crd_nxt = gbase_r;
				BRF_SEL_VECTOR_BASE: crd_nxt = vbase_r;
				BRF_SEL_MAC_HIGH: crd_nxt = mac_high_r;
				BRF_SEL_MAC_LOW: crd_nxt = mac_low_r;
				BRF_SEL_RETURN_LINK: crd_nxt = rlink_r;
				BRF_SEL_PC: crd_nxt = pc_r;
				BRF_SEL_ALT_BANK: crd_nxt = st_rd_c;
				default: crd_nxt = '0;
			endcase
		end else if (ctl_any) begin
			crd_nxt = '0;
		end
	end

	// The index copy of register zero is refreshed through a private read slot each cycle.
	assign r0_live = u_store.mem_r[phys_addr(4'h0, bank_use)];

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rda_r <= `BRF_WORD_RST;
			rdb_r <= `BRF_WORD_RST;
			idx0_r <= `BRF_WORD_RST;
			crd_r <= `BRF_WORD_RST;
			fault_r <= 1'b0;
		end else begin
			rda_r <= rda_nxt;
			rdb_r <= rdb_nxt;
			idx0_r <= idx0_nxt;
			crd_r <= crd_nxt;
			fault_r <= fault_nxt;
		end
	end

	// Outputs, all straight from registers.
	assign GEN_RD_A_DATA = rda_r;
	assign GEN_RD_B_DATA = rdb_r;
	assign INDEX_R0 = idx0_r;
	assign CTL_RDATA = crd_r;
	assign CTL_FAULT = fault_r;
	assign MODE_BIT = stat_r[`BRF_STAT_MODE_POS];
	assign BANK_SELECT_BIT = stat_r[`BRF_STAT_BANK_POS];
	assign EXCEPTION_HOLD_FLAG = stat_r[`BRF_STAT_HOLD_POS];
	assign INTERRUPT_MASK_FIELD = stat_r[`BRF_STAT_IMASK_MSB:`BRF_STAT_IMASK_LSB];
	assign STATUS_WORD = stat_r;
	assign PC_VALUE = pc_r;
	assign GLOBAL_BASE = gbase_r;
	assign VECTOR_BASE = vbase_r;

endmodule : brf_register_file

// [dv/brf_register_file_sva.sv]
`timescale 1ns/1ps
// Port-level checks of the register file; it sees only the top-level ports.
module brf_register_file_sva (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic LOAD_CONTROL_OP,
	input wire logic STORE_CONTROL_OP,
	input wire logic [3:0] CTL_SEL,
	input wire logic [31:0] CTL_WDATA,
	input wire logic EXC_TAKE,
	input wire logic [31:0] EXC_TARGET,
	input wire logic RETURN_FROM_EXCEPTION,
	input wire logic [31:0] CTL_RDATA,
	input wire logic CTL_FAULT,
	input wire logic MODE_BIT,
	input wire logic BANK_SELECT_BIT,
	input wire logic EXCEPTION_HOLD_FLAG,
	input wire logic [3:0] INTERRUPT_MASK_FIELD,
	input wire logic [31:0] PC_VALUE,
	input wire logic [31:0] VECTOR_BASE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// Reset values must appear after every reset edge, so this one is not disabled by reset.
	property p_rst;
		disable iff (1'b0) RST |=> PC_VALUE == 32'hA0000000 && VECTOR_BASE == 32'h00000000
			&& {MODE_BIT, BANK_SELECT_BIT, EXCEPTION_HOLD_FLAG, INTERRUPT_MASK_FIELD} == 7'h7F;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_exc;
		EXC_TAKE |=> MODE_BIT && BANK_SELECT_BIT && EXCEPTION_HOLD_FLAG && PC_VALUE == $past(EXC_TARGET);
	endproperty
	a_exc: assert property (p_exc) else $error("exception entry wrong");
	// One quiet cycle between entry and return, so no saved pc load can intervene.
	property p_rte;
		EXC_TAKE ##1 (!EXC_TAKE && !LOAD_CONTROL_OP && !RETURN_FROM_EXCEPTION)
			##1 (RETURN_FROM_EXCEPTION && !EXC_TAKE) |=> PC_VALUE == $past(PC_VALUE, 3);
	endproperty
	a_rte: assert property (p_rte) else $error("return did not restore pc");
	property p_ufault;
		STORE_CONTROL_OP && !MODE_BIT && CTL_SEL inside {4'h1, 4'h2, 4'h4, 4'h9} |=> CTL_FAULT && CTL_RDATA == 32'h0;
	endproperty
	a_ufault: assert property (p_ufault) else $error("user store not refused");
	property p_free;
		(LOAD_CONTROL_OP || STORE_CONTROL_OP) && CTL_SEL inside {4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8} |=> !CTL_FAULT;
	endproperty
	a_free: assert property (p_free) else $error("open register refused");
	property p_pcrd;
		STORE_CONTROL_OP && CTL_SEL == 4'h8 |=> CTL_RDATA == $past(PC_VALUE);
	endproperty
	a_pcrd: assert property (p_pcrd) else $error("pc store wrong");
	// Privileged status bits must survive a user write.
	property p_upriv;
		LOAD_CONTROL_OP && CTL_SEL == 4'h0 && !MODE_BIT && !EXC_TAKE && !RETURN_FROM_EXCEPTION |=> $stable(MODE_BIT)
			&& $stable(BANK_SELECT_BIT) && $stable(EXCEPTION_HOLD_FLAG) && $stable(INTERRUPT_MASK_FIELD);
	endproperty
	a_upriv: assert property (p_upriv) else $error("user changed privileged bits");
	property p_uvb;
		LOAD_CONTROL_OP && CTL_SEL == 4'h4 && !MODE_BIT |=> $stable(VECTOR_BASE);
	endproperty
	a_uvb: assert property (p_uvb) else $error("user wrote vector base");
	property p_pvb;
		LOAD_CONTROL_OP && CTL_SEL == 4'h4 && MODE_BIT && !EXC_TAKE |=> VECTOR_BASE == $past(CTL_WDATA);
	endproperty
	a_pvb: assert property (p_pvb) else $error("vector base load lost");
endmodule : brf_register_file_sva

bind brf_register_file brf_register_file_sva CHK (.*);

// [dv/brf_exec_model.sv]
`timescale 1ns/1ps
// Execution side: owns the request inputs and raises at most one strobe per call.
module brf_exec_model (
	input wire logic clk,
	output logic [5:0] stb,
	output logic [3:0] idx,
	output logic [3:0] rdb,
	output logic [3:0] sel,
	output logic [31:0] d
);
	// Strobes: 0 general write, 1 load, 2 store, 3 exception, 4 return, 5 pc write; -1 reads only.
	initial begin
		stb = 6'h00;
		idx = 4'h0;
		rdb = 4'hF;
		sel = 4'h0;
		d = 32'h0;
	end

	// Set up just after an edge, hold through the next edge, then release.
	task automatic go(input int k, input logic [3:0] i, input logic [3:0] s, input logic [31:0] v);
		@(posedge clk);
		#1;
		idx = i;
		rdb = ~i;
		sel = s;
		d = v;
		if (k >= 0) stb = 6'h01 << k;
		@(posedge clk);
		#1;
		stb = 6'h00;
		d = ~v; // Released data inverts so a stale value cannot pass.
	endtask : go
endmodule : brf_exec_model

// [dv/banked_cpu_register_file_tb.sv]
`timescale 1ns/1ps
module banked_cpu_register_file_tb;
	logic CLK_SYS;
	logic RST;
	logic [5:0] stb;
	logic [3:0] idx, rdb, sel, im;
	logic [31:0] d, ra, rb, ir0, crd, sw, pc, vb, gb, lf, t;
	logic flt, md, bs, eh;
	logic [31:0] b0 [8], b1 [8], up [8];
	int err_count, cmp_count;

	// Free-running core clock.
	initial begin
		CLK_SYS = 1'b0;
		forever #2 CLK_SYS = ~CLK_SYS;
	end

	brf_exec_model PTN (.clk(CLK_SYS), .stb(stb), .idx(idx), .rdb(rdb), .sel(sel), .d(d));
	brf_register_file DUT (.CLK_SYS(CLK_SYS), .RST(RST), .GEN_RD_A_IDX(idx), .GEN_RD_B_IDX(rdb),
		.GEN_WR_EN(stb[0]), .GEN_WR_IDX(idx), .GEN_WR_DATA(d), .LOAD_CONTROL_OP(stb[1]),
		.STORE_CONTROL_OP(stb[2]), .CTL_SEL(sel), .CTL_BANK_IDX(idx[2:0]), .CTL_WDATA(d), .EXC_TAKE(stb[3]),
		.EXC_TARGET(d), .RETURN_FROM_EXCEPTION(stb[4]), .PC_WR_EN(stb[5]), .PC_WR_DATA(d),
		.GEN_RD_A_DATA(ra), .GEN_RD_B_DATA(rb), .INDEX_R0(ir0), .CTL_RDATA(crd), .CTL_FAULT(flt),
		.MODE_BIT(md), .BANK_SELECT_BIT(bs), .EXCEPTION_HOLD_FLAG(eh), .INTERRUPT_MASK_FIELD(im),
		.STATUS_WORD(sw), .PC_VALUE(pc), .GLOBAL_BASE(gb), .VECTOR_BASE(vb));

	// Helpers: random source, expected general value, expected refusal.
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	function automatic logic [31:0] eg(input int k, input int i);
		return (i > 7) ? up[i - 8] : (k == 1) ? b1[i] : b0[i];
	endfunction : eg
	function automatic logic fx(input logic m, input logic [3:0] s);
		return (s > 4'h9) || (!m && (s == 4'h1 || s == 4'h2 || s == 4'h4 || s == 4'h9));
	endfunction : fx

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// Reset for four cycles, then check the documented start state.
	task automatic reset_chk;
		RST = 1'b1;
		repeat (4) @(posedge CLK_SYS);
		#1;
		RST = 1'b0;
		chk({25'h0, md, bs, eh, im}, 32'h7F);
		chk(sw & 32'h8FFFFC0C, 32'h0);
		chk(pc, 32'hA0000000);
		chk(vb, 32'h0);
		$display("test reset done");
	endtask : reset_chk

	// A hang is cut short and counted.
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		err_count++;
		results();
	end

	// Main sequence: banks, user refusals, exception round trip, manual reset.
	initial begin
		err_count = 0;
		cmp_count = 0;
		lf = 32'h278D;
		reset_chk();
		for (int i = 0; i < 24; i++) begin
			lf = nx(lf);
			if (i == 16) PTN.go(1, 4'h0, 4'h0, 32'h500000F0);
			if (i < 8) b1[i] = lf;
			else if (i < 16) up[i - 8] = lf;
			else b0[i - 16] = lf;
			PTN.go(0, 4'(i % 16), 4'h0, lf);
		end
		for (int k = 0; k < 3; k++) begin
			PTN.go(1, 4'h0, 4'h0, (k == 0) ? 32'h500000F0 : (k == 1) ? 32'h700000F0 : 32'h000000F0);
			for (int i = 0; i < 16; i++) begin
				PTN.go(-1, 4'(i), 4'h0, 32'h0);
				chk(ra, eg(k, i));
				chk(rb, eg(k, 15 - i));
				PTN.go(2, 4'(i), 4'h9, 32'h0);
				chk({31'h0, flt}, {31'h0, k == 2});
				chk(crd, (k == 2) ? 32'h0 : (k == 1) ? b0[i % 8] : b1[i % 8]);
			end
			chk(ir0, eg(k, 0));
			$display("test bank setting %0d done", k);
		end
		for (int s = 0; s < 16; s++) begin
			PTN.go(2, 4'h0, 4'(s), 32'h0);
			chk({31'h0, flt}, {31'h0, fx(1'b0, 4'(s))});
			if (s == 0) chk(crd, 32'h0);
			if (s == 3 || (s > 4 && s < 8)) begin
				lf = nx(lf);
				PTN.go(1, 4'h0, 4'(s), lf);
				PTN.go(2, 4'h0, 4'(s), 32'h0);
				chk(crd, lf);
				if (s == 3) chk(gb, lf);
			end
		end
		PTN.go(1, 4'h0, 4'h0, 32'h70000000);
		chk({25'h0, md, bs, eh, im}, 32'h0F);
		PTN.go(1, 4'h0, 4'h4, lf);
		chk(vb, 32'h0);
		PTN.go(5, 4'h0, 4'h0, lf);
		PTN.go(2, 4'h0, 4'h8, 32'h0);
		chk(crd, lf);
		$display("test user access done");
		t = pc;
		lf = nx(lf);
		PTN.go(3, 4'h0, 4'h0, lf);
		chk({29'h0, md, bs, eh}, 32'h7);
		chk(pc, lf);
		PTN.go(2, 4'h0, 4'h2, 32'h0);
		chk(crd, t);
		PTN.go(1, 4'h0, 4'h4, lf);
		chk(vb, lf);
		PTN.go(4, 4'h0, 4'h0, 32'h0);
		chk(pc, t);
		chk({31'h0, md}, 32'h0);
		// Entry and return with one idle cycle between them, the tightest the model can pace.
		lf = nx(lf);
		PTN.go(3, 4'h0, 4'h0, lf);
		PTN.go(4, 4'h0, 4'h0, 32'h0);
		chk(pc, t);
		$display("test exception done");
		reset_chk();
		results();
	end
endmodule : banked_cpu_register_file_tb
